// file: cam_ctrl_pkg.sv
package cam_ctrl_pkg;

  // Seven-bit target address of the control port on the I2C bus.
  localparam logic [6:0]  I2C_TARGET_ADDR   = 7'h20;

  // Power off and sensor held in reset until the host says otherwise.
  localparam logic [7:0]  PORT_RESET        = 8'h00;

  localparam logic [7:0]  OFF_PORT_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_IRQ_ENABLE    = 8'h08;
  localparam logic [7:0]  OFF_IRQ_CLEAR     = 8'h0c;
  localparam logic [7:0]  OFF_SENSOR_CLK    = 8'h10;
  localparam logic [7:0]  OFF_PIN_STATE     = 8'h14;
  localparam logic [7:0]  OFF_TARGET_ADDR   = 8'h18;

  localparam int          IRQ_W             = 4;
  localparam int          IRQ_SENSOR_TRIG   = 0;
  localparam int          IRQ_STROBE        = 1;
  localparam int          IRQ_OVERCURRENT   = 2;
  localparam int          IRQ_PORT_WRITE    = 3;
  localparam logic [3:0]  IRQ_ENABLE_RESET  = 4'h0;

  // Sensor clock half period in system clocks; 125 MHz / 8 by default.
  localparam int          CLK_PERIOD_NS     = 8;
  localparam logic [15:0] SENSOR_HALF_RESET = 16'h0004;

  localparam int          I2C_BITS_PER_BYTE = 8;

  typedef struct packed {
    logic reserved;
    logic trigger_source_select;
    logic trigger_invert;
    logic user_out_pin_source_select;
    logic user_out_pin_drive_type;
    logic bit_a;
    logic sensor_reset_n;
    logic sensor_power_enable;
  } port_ctrl_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage

// file: camera_trigger_output_control.sv
`timescale 1ns/1ps
module camera_trigger_output_control #(
  parameter logic [6:0] TARGET_ADDR = cam_ctrl_pkg::I2C_TARGET_ADDR
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        sensor_strobe_i,
  input  wire logic        board_external_trig_i,
  input  wire logic        link_trig_i,
  input  wire logic        overcurrent_i,
  output logic             sensor_trig_o,
  output logic             sensor_power_enable_o,
  output logic             sensor_reset_n_o,
  output logic             sensor_clk_o,
  output logic             user_out_pin_o,
  output logic             user_out_pin_oe_n_o,
  output logic             green_indicator_o,
  output logic             red_overcurrent_indicator_o,
  output logic             irq_o
);

  cam_ctrl_pkg::apb_req_t   req;
  cam_ctrl_pkg::port_ctrl_t port;
  cam_ctrl_pkg::port_ctrl_t next_port;

  logic [cam_ctrl_pkg::IRQ_W-1:0] irq_status;
  logic [cam_ctrl_pkg::IRQ_W-1:0] irq_enable;
  logic [cam_ctrl_pkg::IRQ_W-1:0] irq_clear;
  logic [cam_ctrl_pkg::IRQ_W-1:0] irq_event;

  logic [15:0] sensor_half;
  logic [15:0] clk_cnt;
  logic [7:0]  i2c_wr_data;
  logic        i2c_wr_stb;
  logic        i2c_sda_oe_n;

  logic [1:0]  strobe_sync;
  logic [1:0]  ext_sync;
  logic [1:0]  link_sync;
  logic [1:0]  ocur_sync;
  logic        strobe;
  logic        ext_trig;
  logic        link_trig;
  logic        ocur;
  logic        strobe_q;

  logic        ext_trig_eff;
  logic        next_trig;
  logic        out_level;
  logic        next_out;
  logic        next_oe_n;
  logic        next_green;
  logic        next_red;

  logic        wr_access;
  logic        rd_access;
  logic [31:0] next_rdata;

  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      cam_ctrl_pkg::OFF_PORT_CTRL,
      cam_ctrl_pkg::OFF_IRQ_STATUS,
      cam_ctrl_pkg::OFF_IRQ_ENABLE,
      cam_ctrl_pkg::OFF_IRQ_CLEAR,
      cam_ctrl_pkg::OFF_SENSOR_CLK,
      cam_ctrl_pkg::OFF_PIN_STATE,
      cam_ctrl_pkg::OFF_TARGET_ADDR: is_mapped = 1'b1;
      default:                       is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic hits(input cam_ctrl_pkg::apb_req_t r,
                                input logic [7:0]             off);
    hits = r.addr == off;
  endfunction

  assign req.sel    = psel_i;
  assign req.enable = penable_i;
  assign req.write  = pwrite_i;
  assign req.addr   = paddr_i;
  assign req.wdata  = pwdata_i;

  i2c_port_target #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_i2c (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .port_i     (port),
    .sda_oe_n_o (i2c_sda_oe_n),
    .wr_data_o  (i2c_wr_data),
    .wr_stb_o   (i2c_wr_stb)
  );

  // Pins from the board are asynchronous and pass two flops first.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      strobe_sync <= 2'h0;
      ext_sync    <= 2'h0;
      link_sync   <= 2'h0;
      ocur_sync   <= 2'h0;
      strobe_q    <= 1'b0;
    end else begin
      strobe_sync <= {strobe_sync[0], sensor_strobe_i};
      ext_sync    <= {ext_sync[0], board_external_trig_i};
      link_sync   <= {link_sync[0], link_trig_i};
      ocur_sync   <= {ocur_sync[0], overcurrent_i};
      strobe_q    <= strobe_sync[1];
    end
  end

  assign strobe    = strobe_sync[1];
  assign ext_trig  = ext_sync[1];
  assign link_trig = link_sync[1];
  assign ocur      = ocur_sync[1];

  assign wr_access = req.sel & req.enable & ~pready_o & req.write;
  assign rd_access = req.sel & req.enable & ~pready_o & ~req.write;

  // An I2C write takes priority over a bus write in the same cycle,
  // since the I2C host cannot be stalled or told it lost.
  always_comb begin
    next_port = port;
    if (i2c_wr_stb) begin
      next_port = i2c_wr_data;
    end else if (wr_access && hits(req, cam_ctrl_pkg::OFF_PORT_CTRL)) begin
      next_port = req.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      port <= cam_ctrl_pkg::PORT_RESET;
    end else begin
      port <= next_port;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sensor_power_enable_o <= 1'b0;
      sensor_reset_n_o      <= 1'b0;
    end else begin
      sensor_power_enable_o <= port.sensor_power_enable;
      sensor_reset_n_o      <= port.sensor_reset_n;
    end
  end

  always_comb begin
    ext_trig_eff = ext_trig ^ port.trigger_invert;
    next_trig    = port.trigger_source_select ? ext_trig_eff : link_trig;
    out_level    = port.user_out_pin_source_select ? port.bit_a : strobe;
    if (port.user_out_pin_drive_type) begin
      next_out  = out_level;
      next_oe_n = 1'b0;
    end else begin
      next_out  = 1'b0;
      next_oe_n = out_level;
    end
    next_green = ~port.user_out_pin_source_select & port.bit_a;
    next_red   = port.user_out_pin_drive_type & ocur;
  end

  // The output flop is the only stage after the pin synchronisers.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sensor_trig_o               <= 1'b0;
      user_out_pin_o              <= 1'b0;
      user_out_pin_oe_n_o         <= 1'b1;
      green_indicator_o           <= 1'b0;
      red_overcurrent_indicator_o <= 1'b0;
      sda_o                       <= 1'b0;
      sda_oe_n_o                  <= 1'b1;
    end else begin
      sensor_trig_o               <= next_trig;
      user_out_pin_o              <= next_out;
      user_out_pin_oe_n_o         <= next_oe_n;
      green_indicator_o           <= next_green;
      red_overcurrent_indicator_o <= next_red;
      sda_o                       <= 1'b0;
      sda_oe_n_o                  <= i2c_sda_oe_n;
    end
  end

  // Sensor clock divider.
  // The clock is parked low while the sensor supply is off so that no
  // edges reach an unpowered input.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clk_cnt      <= 16'h0000;
      sensor_clk_o <= 1'b0;
    end else if (!port.sensor_power_enable) begin
      clk_cnt      <= 16'h0000;
      sensor_clk_o <= 1'b0;
    end else if (clk_cnt + 16'h0001 >= sensor_half) begin
      clk_cnt      <= 16'h0000;
      sensor_clk_o <= ~sensor_clk_o;
    end else begin
      clk_cnt <= clk_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sensor_half <= cam_ctrl_pkg::SENSOR_HALF_RESET;
    end else if (wr_access && hits(req, cam_ctrl_pkg::OFF_SENSOR_CLK)) begin
      // A zero divisor is lifted to one; both would toggle the clock every cycle.
      sensor_half <= (req.wdata[15:0] == 16'h0000) ? 16'h0001
                                                   : req.wdata[15:0];
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[cam_ctrl_pkg::IRQ_SENSOR_TRIG] = next_trig & ~sensor_trig_o;
    irq_event[cam_ctrl_pkg::IRQ_STROBE]      = strobe & ~strobe_q;
    irq_event[cam_ctrl_pkg::IRQ_OVERCURRENT] =
      next_red & ~red_overcurrent_indicator_o;
    irq_event[cam_ctrl_pkg::IRQ_PORT_WRITE]  = i2c_wr_stb;
    irq_clear = '0;
    if (wr_access && hits(req, cam_ctrl_pkg::OFF_IRQ_CLEAR)) begin
      irq_clear = req.wdata[cam_ctrl_pkg::IRQ_W-1:0];
    end
  end

  // A new event in the cycle of its clear keeps the bit set.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_enable <= cam_ctrl_pkg::IRQ_ENABLE_RESET;
    end else if (wr_access && hits(req, cam_ctrl_pkg::OFF_IRQ_ENABLE)) begin
      irq_enable <= req.wdata[cam_ctrl_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (req.addr)
      cam_ctrl_pkg::OFF_PORT_CTRL:   next_rdata[7:0] = port;
      cam_ctrl_pkg::OFF_IRQ_STATUS:
        next_rdata[cam_ctrl_pkg::IRQ_W-1:0] = irq_status;
      cam_ctrl_pkg::OFF_IRQ_ENABLE:
        next_rdata[cam_ctrl_pkg::IRQ_W-1:0] = irq_enable;
      cam_ctrl_pkg::OFF_SENSOR_CLK:  next_rdata[15:0] = sensor_half;
      cam_ctrl_pkg::OFF_PIN_STATE:
        next_rdata[5:0] = {ocur, link_trig, ext_trig, strobe,
                           sensor_trig_o, out_level};
      cam_ctrl_pkg::OFF_TARGET_ADDR: next_rdata[6:0] = TARGET_ADDR;
      default:                       next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= req.sel & req.enable & ~pready_o;
      pslverr_o <= req.sel & req.enable & ~pready_o & ~is_mapped(req.addr);
      if (rd_access) begin
        prdata_o <= next_rdata;
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

endmodule

// file: i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic clk_sys_i,
  input  wire logic sda_oe_n_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic host_sda = 1'b1;

  // The line is pulled up, so it is low whenever either side pulls it.
  assign sda_o = host_sda & (sda_oe_n_i !== 1'b0);
  initial scl_o = 1'b1;

  // Each phase lasts 16 clocks, well above the target's minimum low time.
  task automatic hold(input logic c, input logic d);
    @(posedge clk_sys_i);
    scl_o <= c;
    host_sda <= d;
    repeat (15) @(posedge clk_sys_i);
  endtask

  // Address byte, then a port byte with bit seven zero.
  task automatic write_port(input logic [6:0] adr, input logic [7:0] dat,
                            output logic acked);
    logic [17:0] bits;
    bits = {adr, 1'b0, 1'b1, 1'b0, dat[6:0], 1'b1};
    acked = 1'b1;
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
    for (int i = 17; i >= 0; i--) begin
      hold(1'b0, host_sda);
      hold(1'b0, bits[i]);
      hold(1'b1, bits[i]);
      if ((i == 9 || i == 0) && sda_o !== 1'b0) begin
        acked = 1'b0;
      end
    end
    hold(1'b0, host_sda);
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask

  // Address byte with the read bit, one port byte, then a NACK.
  task automatic read_port(input logic [6:0] adr, output logic [7:0] dat,
                           output logic acked);
    logic [17:0] bits;
    bits = {adr, 1'b1, 1'b1, 8'hff, 1'b1};
    acked = 1'b1;
    dat = 8'h00;
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
    for (int i = 17; i >= 0; i--) begin
      hold(1'b0, host_sda);
      hold(1'b0, bits[i]);
      hold(1'b1, bits[i]);
      if (i == 9 && sda_o !== 1'b0) begin
        acked = 1'b0;
      end
      if (i >= 1 && i <= 8) begin
        dat[i-1] = sda_o;
      end
    end
    hold(1'b0, host_sda);
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask
endmodule

// file: i2c_port_target.sv
`timescale 1ns/1ps
module i2c_port_target #(
  parameter logic [6:0] TARGET_ADDR = cam_ctrl_pkg::I2C_TARGET_ADDR
) (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] port_i,
  output logic            sda_oe_n_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_stb_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ,
    ST_READ_ACK
  } i2c_state_t;

  i2c_state_t state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic       rw;
  logic       ack_seen;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_done;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  assign scl_rise   = scl_sync[1] & ~scl_q;
  assign scl_fall   = ~scl_sync[1] & scl_q;
  assign start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  assign byte_done  = cnt == 4'(cam_ctrl_pkg::I2C_BITS_PER_BYTE);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state      <= ST_IDLE;
      cnt        <= 4'h0;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      ack_seen   <= 1'b0;
      sda_oe_n_o <= 1'b1;
      wr_data_o  <= 8'h00;
      wr_stb_o   <= 1'b0;
    end else begin
      wr_stb_o <= 1'b0;
      if (start_cond) begin
        state      <= ST_ADDR;
        cnt        <= 4'h0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_cond) begin
        state      <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (state)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_sync[1]};
              cnt   <= cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              ack_seen <= 1'b0;
              if (state == ST_WRITE) begin
                wr_data_o  <= shreg;
                wr_stb_o   <= 1'b1;
                sda_oe_n_o <= 1'b0;
                state      <= ST_ACK_WRITE;
              end else if (shreg[7:1] == TARGET_ADDR) begin
                rw         <= shreg[0];
                sda_oe_n_o <= 1'b0;
                state      <= ST_ACK_ADDR;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK_WRITE: begin
            if (scl_rise) begin
              ack_seen <= 1'b1;
            end else if (scl_fall && ack_seen) begin
              sda_oe_n_o <= 1'b1;
              cnt        <= 4'h0;
              state      <= ST_WRITE;
            end
          end
          ST_ACK_ADDR, ST_READ_ACK: begin
            if (scl_rise) begin
              if (state == ST_ACK_ADDR || !sda_sync[1]) begin
                ack_seen <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end else if (scl_fall && ack_seen) begin
              ack_seen <= 1'b0;
              if (rw) begin
                shreg      <= port_i;
                sda_oe_n_o <= port_i[7];
                cnt        <= 4'h1;
                state      <= ST_READ;
              end else begin
                sda_oe_n_o <= 1'b1;
                cnt        <= 4'h0;
                state      <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (byte_done) begin
                sda_oe_n_o <= 1'b1;
                state      <= ST_READ_ACK;
              end else begin
                shreg      <= {shreg[6:0], 1'b0};
                sda_oe_n_o <= shreg[6];
                cnt        <= cnt + 4'h1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  paddr_i = 8'h00;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic        sensor_strobe_i = 1'b0;
  logic        board_external_trig_i = 1'b0;
  logic        link_trig_i = 1'b0;
  logic        overcurrent_i = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, scl_i, sda_i, sda_o, sda_oe_n_o;
  logic        sensor_trig_o, sensor_power_enable_o, sensor_reset_n_o;
  logic        sensor_clk_o, user_out_pin_o, user_out_pin_oe_n_o;
  logic        green_indicator_o, red_overcurrent_indicator_o, irq_o;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          cmp_count = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  camera_trigger_output_control DUT (
    .clk_sys_i, .srst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_i, .sda_i, .sda_o,
    .sda_oe_n_o, .sensor_strobe_i, .board_external_trig_i, .link_trig_i,
    .overcurrent_i, .sensor_trig_o, .sensor_power_enable_o,
    .sensor_reset_n_o, .sensor_clk_o, .user_out_pin_o, .user_out_pin_oe_n_o,
    .green_indicator_o, .red_overcurrent_indicator_o, .irq_o
  );

  i2c_host_model host (
    .clk_sys_i (clk_sys_i),
    .sda_oe_n_i(sda_oe_n_o),
    .scl_o     (scl_i),
    .sda_o     (sda_i)
  );

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    check("pready", 32'h1, {31'h0, pready_o});
  endtask

  // Pins follow their inputs three clocks later; five leaves margin.
  task automatic settle;
    repeat (5) @(posedge clk_sys_i);
  endtask

  task automatic test_i2c;
    logic       ack;
    logic [7:0] rdb;
    host.write_port(cam_ctrl_pkg::I2C_TARGET_ADDR ^ 7'h01, 8'h03, ack);
    check("stray ack", 32'h0, {31'h0, ack});
    apb(1'b0, cam_ctrl_pkg::OFF_PORT_CTRL, 32'h0);
    check("port kept", 32'h0, rd);
    host.write_port(cam_ctrl_pkg::I2C_TARGET_ADDR, 8'h03, ack);
    settle;
    check("ack", 32'h1, {31'h0, ack});
    check("power on", 32'h3, {30'h0, sensor_power_enable_o,
                              sensor_reset_n_o});
    host.write_port(cam_ctrl_pkg::I2C_TARGET_ADDR, 8'h01, ack);
    settle;
    check("in reset", 32'h2, {30'h0, sensor_power_enable_o,
                              sensor_reset_n_o});
    host.read_port(cam_ctrl_pkg::I2C_TARGET_ADDR, rdb, ack);
    check("read ack", 32'h1, {31'h0, ack});
    check("read port", 32'h01, {24'h0, rdb});
    check("sda level", 32'h0, {31'h0, sda_o});
    apb(1'b0, cam_ctrl_pkg::OFF_IRQ_STATUS, 32'h0);
    check("write event", 32'h8, rd & 32'h8);
    $display("done i2c");
  endtask

  task automatic test_trigger;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, cam_ctrl_pkg::OFF_PORT_CTRL, {25'h0, m[1], m[0], 5'h03});
      board_external_trig_i <= m[2];
      link_trig_i <= ~m[2];
      settle;
      check("trigger", {31'h0, m[1] ? m[2] ^ m[0] : ~m[2]},
            {31'h0, sensor_trig_o});
    end
    $display("done trigger");
  endtask

  task automatic test_user_out_pin;
    logic lvl;
    for (int m = 0; m < 16; m++) begin
      lvl = m[2] ? m[1] : m[3];
      apb(1'b1, cam_ctrl_pkg::OFF_PORT_CTRL, {27'h0, m[2], m[0], m[1], 2'h3});
      sensor_strobe_i <= m[3];
      settle;
      check("user_out_pin", {29'h0, m[0] & lvl, ~m[0] & lvl, ~m[2] & m[1]},
            {29'h0, user_out_pin_o, user_out_pin_oe_n_o,
             green_indicator_o});
    end
    $display("done user_out_pin");
  endtask

  task automatic test_events;
    int   rises;
    logic prev;
    apb(1'b1, cam_ctrl_pkg::OFF_IRQ_CLEAR, 32'hf);
    apb(1'b1, cam_ctrl_pkg::OFF_PORT_CTRL, 32'h08);
    overcurrent_i <= 1'b1;
    settle;
    check("red", 32'h1, {31'h0, red_overcurrent_indicator_o});
    apb(1'b0, cam_ctrl_pkg::OFF_IRQ_STATUS, 32'h0);
    check("status", 32'h4, rd & 32'h4);
    check("irq off", 32'h0, {31'h0, irq_o});
    apb(1'b1, cam_ctrl_pkg::OFF_IRQ_ENABLE, 32'h4);
    settle;
    check("irq on", 32'h1, {31'h0, irq_o});
    apb(1'b1, cam_ctrl_pkg::OFF_IRQ_CLEAR, 32'h4);
    settle;
    check("irq clr", 32'h0, {31'h0, irq_o});
    apb(1'b1, cam_ctrl_pkg::OFF_PORT_CTRL, 32'h01);
    settle;
    check("red od", 32'h0, {31'h0, red_overcurrent_indicator_o});
    rises = 0;
    prev = sensor_clk_o;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys_i);
      if (sensor_clk_o === 1'b1 && prev === 1'b0) begin
        rises++;
      end
      prev = sensor_clk_o;
    end
    check("clk rises", 32'(40 / (2 * cam_ctrl_pkg::SENSOR_HALF_RESET)),
          32'(rises));
    apb(1'b1, cam_ctrl_pkg::OFF_SENSOR_CLK, 32'h0);
    apb(1'b0, cam_ctrl_pkg::OFF_SENSOR_CLK, 32'h0);
    check("half min", 32'h1, rd);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, cam_ctrl_pkg::OFF_TARGET_ADDR, 32'h7f);
    apb(1'b0, cam_ctrl_pkg::OFF_TARGET_ADDR, 32'h0);
    check("address ro", {25'h0, cam_ctrl_pkg::I2C_TARGET_ADDR}, rd);
    $display("done events");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    test_i2c;
    test_trigger;
    test_user_out_pin;
    test_events;
    finish_test;
  end

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    finish_test;
  end
endmodule

// file: trigger_ctrl_props.sv
`timescale 1ns/1ps
module trigger_ctrl_props (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        scl_i,
  input wire logic        sda_oe_n_o,
  input wire logic        sensor_power_enable_o,
  input wire logic        sensor_reset_n_o,
  input wire logic        sensor_clk_o,
  input wire logic        user_out_pin_o,
  input wire logic        user_out_pin_oe_n_o,
  input wire logic        red_overcurrent_indicator_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  pready_pulse_a:
    assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  slverr_ready_a:
    assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  pready_bound_a:
    assert property (psel_i && penable_i && !pready_o |-> ##[0:2] pready_o)
    else $error("access phase not answered in time");
  rdata_idle_a:
    assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  reset_state_a:
    assert property ($fell(srst_i) |-> !sensor_power_enable_o &&
      !sensor_reset_n_o && user_out_pin_oe_n_o && sda_oe_n_o)
    else $error("outputs not at rest after reset");
  clk_off_a:
    assert property (!sensor_power_enable_o && !$past(sensor_power_enable_o)
      |-> !sensor_clk_o)
    else $error("sensor clock runs with power off");
  red_push_a:
    assert property (red_overcurrent_indicator_o |-> !user_out_pin_oe_n_o)
    else $error("red indicator while pin not driven");
  drive_high_a:
    assert property (user_out_pin_o |-> !user_out_pin_oe_n_o)
    else $error("pin high without push-pull drive");
  sda_edge_a:
    assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data line moved while clock high");
endmodule

bind camera_trigger_output_control trigger_ctrl_props chk (
  .clk_sys_i, .srst_i, .psel_i, .penable_i, .prdata_o, .pready_o,
  .pslverr_o, .scl_i, .sda_oe_n_o, .sensor_power_enable_o,
  .sensor_reset_n_o, .sensor_clk_o, .user_out_pin_o, .user_out_pin_oe_n_o,
  .red_overcurrent_indicator_o
);
